// [logic/scrc_checker.sv]
/*
 Bit-serial section checksum checker. Takes tagged image words, folds address,
 size and data words into a 32-bit running value one bit per clock, and
 compares it against the expected value of a check command.
 Assumes the source holds WORD while WORD_VALID is high and READY is low.
*/
`timescale 1ns/1ps

// Operation
// - A 32-bit running checksum register is updated one input bit per cycle.
// - The reduction step XORs in the polynomial 0x04C11DB7.
// - Per bit, sample the top bit, shift left, XOR the input bit into bit 0, and XOR the polynomial if the top was set.
// - Every complete data word is fed as 32 bits from bit 31 down to bit 0.
// - Section length is counted in bytes, so a length not a multiple of four leaves a partial last word.
// - A partial last word feeds 8, 16 or 24 bits MSB first under masks 0xFF, 0xFFFF or 0xFFFFF.
// - A section's checksum covers the address word, then the size word, then the data, each continuing on.
// - A fresh section starts the running value at zero before the address word.
// - In chained mode the running value carries into the next section without clearing.
// - The source supplies the expected value in the check command and the device compares against it.
// - When failures exceed the permitted maximum the error code 0x4 is recorded.
// - On a checksum error the device raises a corruption message, records the error and restarts boot; BOOT_ERR is set only once failures exceed FAIL_MAX.
module scrc_checker (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic WORD_VALID,
   output logic WORD_READY,
   input scrc_pkg::scrc_word_type WORD,
   input wire logic [3:0] FAIL_MAX,
   output scrc_pkg::scrc_result_type RESULT,
   output logic CORRUPTION_MESSAGE_MSG,
   output logic BOOT_RESTART,
   output logic [3:0] BOOT_ERR,
   output logic [3:0] FAIL_COUNT
);
   scrc_pkg::scrc_state_type state_r;
   logic [31:0] crc_r;
   logic [31:0] shreg_r;
   logic [5:0] bits_r;
   logic cmd_seen_r;
   logic [31:0] crc_nxt;
   logic take;
   logic mismatch;
   logic [31:0] res_val;
   logic [5:0] res_bits;

   assign WORD_READY = (state_r == scrc_pkg::SCRC_IDLE); // Stalls while shifting
   assign take = WORD_VALID && WORD_READY;
   assign mismatch = take && (WORD.kind == scrc_pkg::SCRC_W_EXPECT) && cmd_seen_r
                     && (WORD.data != crc_r);

   // One reduction step on the bit now at the top of the shift register
   always_comb begin
      crc_nxt = {crc_r[30:0], shreg_r[31]};
      if ((crc_r & scrc_pkg::TOP_MASK) != 32'h00000000) begin
         crc_nxt = crc_nxt ^ scrc_pkg::POLY;
      end
   end

   // Residue selection: mask, then left-align so the top feeds first
   always_comb begin
      case (WORD.bytes)
         2'h1: begin
            res_val = (WORD.data & scrc_pkg::RES_MASK1) << (scrc_pkg::WORD_BITS - scrc_pkg::RES_BITS1);
            res_bits = scrc_pkg::RES_BITS1;
         end
         2'h2: begin
            res_val = (WORD.data & scrc_pkg::RES_MASK2) << (scrc_pkg::WORD_BITS - scrc_pkg::RES_BITS2);
            res_bits = scrc_pkg::RES_BITS2;
         end
         2'h3: begin
            // Mask is 20 bits wide yet 24 bits are fed; kept as the loader does
            res_val = (WORD.data & scrc_pkg::RES_MASK3) << (scrc_pkg::WORD_BITS - scrc_pkg::RES_BITS3);
            res_bits = scrc_pkg::RES_BITS3;
         end
         default: begin
            res_val = WORD.data;
            res_bits = scrc_pkg::WORD_BITS;
         end
      endcase
   end

   // Sequencer: shift words bit by bit, handle command and expected words
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         state_r <= scrc_pkg::SCRC_IDLE;
         shreg_r <= 32'h00000000;
         bits_r <= 6'h00;
      end else begin
         case (state_r)
            scrc_pkg::SCRC_IDLE: begin
               if (take) begin
                  case (WORD.kind)
                     scrc_pkg::SCRC_W_ADDR, scrc_pkg::SCRC_W_SIZE: begin
                        shreg_r <= WORD.data;
                        bits_r <= scrc_pkg::WORD_BITS;
                        state_r <= scrc_pkg::SCRC_SHIFT;
                     end
                     scrc_pkg::SCRC_W_DATA: begin
                        shreg_r <= res_val;
                        bits_r <= res_bits;
                        state_r <= scrc_pkg::SCRC_SHIFT;
                     end
                     scrc_pkg::SCRC_W_EXPECT: begin
                        if (cmd_seen_r) begin
                           state_r <= scrc_pkg::SCRC_EXP;
                        end
                     end
                     default: begin
                     end
                  endcase
               end
            end
            scrc_pkg::SCRC_SHIFT: begin
               shreg_r <= {shreg_r[30:0], 1'b0}; // MSB first
               bits_r <= bits_r - 6'h01;
               if (bits_r == 6'h01) begin
                  state_r <= scrc_pkg::SCRC_IDLE;
               end
            end
            scrc_pkg::SCRC_EXP: begin
               state_r <= scrc_pkg::SCRC_IDLE; // One idle gap per check
            end
            default: begin
               state_r <= scrc_pkg::SCRC_IDLE;
            end
         endcase
      end
   end

   // Running checksum; cleared at a fresh section, kept when chained
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         crc_r <= scrc_pkg::CRC_RESET;
      end else if (state_r == scrc_pkg::SCRC_SHIFT) begin
         crc_r <= crc_nxt;
      end else if (take && WORD.kind == scrc_pkg::SCRC_W_ADDR && !WORD.chain) begin
         crc_r <= scrc_pkg::CRC_RESET;
      end
      // Chained sections leave crc_r untouched here
   end

   // Check command tracking: expected word only counts right after the command
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         cmd_seen_r <= 1'b0;
      end else if (take) begin
         cmd_seen_r <= (WORD.kind == scrc_pkg::SCRC_W_CMD) && (WORD.data == scrc_pkg::CMD_CHECK);
      end
   end

   // Compare result pulse, one cycle after the expected word is taken
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         RESULT <= '0;
      end else begin
         RESULT.done <= take && (WORD.kind == scrc_pkg::SCRC_W_EXPECT) && cmd_seen_r;
         RESULT.match <= take && (WORD.kind == scrc_pkg::SCRC_W_EXPECT) && cmd_seen_r
                         && (WORD.data == crc_r);
         if (take && WORD.kind == scrc_pkg::SCRC_W_EXPECT && cmd_seen_r) begin
            RESULT.value <= crc_r;
         end
      end
   end

   // Failure handling; corruption message and boot restart pulse one cycle after each mismatch
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         FAIL_COUNT <= 4'h0;
         BOOT_ERR <= scrc_pkg::ERR_NONE;
         CORRUPTION_MESSAGE_MSG <= 1'b0;
         BOOT_RESTART <= 1'b0;
      end else begin
         CORRUPTION_MESSAGE_MSG <= mismatch;
         BOOT_RESTART <= mismatch;
         if (mismatch) begin
            if (FAIL_COUNT != 4'hf) begin
               FAIL_COUNT <= FAIL_COUNT + 4'h1;
            end
            if (FAIL_COUNT >= FAIL_MAX) begin
               BOOT_ERR <= scrc_pkg::ERR_BAD_CHECKSUM;
            end
         end
      end
   end

   // Length of the current shift run, read only by the assertions below;
   // a small counter keeps 8 to 32 cycle runs cheap to check
   logic [5:0] len_cnt_r;
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         len_cnt_r <= 6'h00;
      end else if (state_r == scrc_pkg::SCRC_SHIFT) begin
         len_cnt_r <= len_cnt_r + 6'h01;
      end else begin
         len_cnt_r <= 6'h00;
      end
   end

   // Assertions
   property p_shift_step;
      @(posedge SYS_CLK) disable iff (!RST_N)
      state_r == scrc_pkg::SCRC_SHIFT |=> crc_r == ({$past(crc_r[30:0]), $past(shreg_r[31])}
         ^ ($past(crc_r[31]) ? scrc_pkg::POLY : 32'h00000000));
   endproperty
   a_shift_step: assert property (p_shift_step) else $error("checksum step wrong");

   property p_poly;
      @(posedge SYS_CLK) disable iff (!RST_N)
      state_r == scrc_pkg::SCRC_SHIFT && crc_r[31]
      |=> (crc_r ^ {$past(crc_r[30:0]), $past(shreg_r[31])}) == 32'h04c11db7;
   endproperty
   a_poly: assert property (p_poly) else $error("polynomial not applied");

   property p_word_len;
      @(posedge SYS_CLK) disable iff (!RST_N)
      take && (WORD.kind == scrc_pkg::SCRC_W_ADDR || WORD.kind == scrc_pkg::SCRC_W_SIZE)
      |=> ##31 (state_r == scrc_pkg::SCRC_SHIFT && len_cnt_r == 6'h1f) ##1 state_r == scrc_pkg::SCRC_IDLE;
   endproperty
   a_word_len: assert property (p_word_len) else $error("word not 32 bits");

   property p_data_len;
      @(posedge SYS_CLK) disable iff (!RST_N)
      take && WORD.kind == scrc_pkg::SCRC_W_DATA && WORD.bytes == 2'h0
      |=> ##31 (state_r == scrc_pkg::SCRC_SHIFT && len_cnt_r == 6'h1f) ##1 state_r == scrc_pkg::SCRC_IDLE;
   endproperty
   a_data_len: assert property (p_data_len) else $error("data word not 32 bits");

   property p_res1;
      @(posedge SYS_CLK) disable iff (!RST_N)
      take && WORD.kind == scrc_pkg::SCRC_W_DATA && WORD.bytes == 2'h1
      |=> (state_r == scrc_pkg::SCRC_SHIFT) [*8] ##1 state_r == scrc_pkg::SCRC_IDLE;
   endproperty
   a_res1: assert property (p_res1) else $error("one-byte residue length wrong");

   property p_res2;
      @(posedge SYS_CLK) disable iff (!RST_N)
      take && WORD.kind == scrc_pkg::SCRC_W_DATA && WORD.bytes == 2'h2
      |=> ##15 (state_r == scrc_pkg::SCRC_SHIFT && len_cnt_r == 6'h0f) ##1 state_r == scrc_pkg::SCRC_IDLE;
   endproperty
   a_res2: assert property (p_res2) else $error("two-byte residue length wrong");

   property p_res3;
      @(posedge SYS_CLK) disable iff (!RST_N)
      take && WORD.kind == scrc_pkg::SCRC_W_DATA && WORD.bytes == 2'h3
      |=> ##23 (state_r == scrc_pkg::SCRC_SHIFT && len_cnt_r == 6'h17) ##1 state_r == scrc_pkg::SCRC_IDLE;
   endproperty
   a_res3: assert property (p_res3) else $error("three-byte residue length wrong");

   property p_fresh;
      @(posedge SYS_CLK) disable iff (!RST_N)
      take && WORD.kind == scrc_pkg::SCRC_W_ADDR && !WORD.chain
      |=> crc_r == 32'h00000000;
   endproperty
   a_fresh: assert property (p_fresh) else $error("fresh section not from zero");

   property p_chain;
      @(posedge SYS_CLK) disable iff (!RST_N)
      take && WORD.kind == scrc_pkg::SCRC_W_ADDR && WORD.chain |=> crc_r == $past(crc_r);
   endproperty
   a_chain: assert property (p_chain) else $error("chained value lost");

   property p_pulse;
      @(posedge SYS_CLK) disable iff (!RST_N)
      take && WORD.kind == scrc_pkg::SCRC_W_EXPECT && cmd_seen_r
      |=> RESULT.done && RESULT.match == ($past(WORD.data) == $past(crc_r)) ##1 !RESULT.done;
   endproperty
   a_pulse: assert property (p_pulse) else $error("result pulse wrong");

   property p_err;
      @(posedge SYS_CLK) disable iff (!RST_N)
      mismatch && FAIL_COUNT >= FAIL_MAX |=> BOOT_ERR == 4'h4 && CORRUPTION_MESSAGE_MSG && BOOT_RESTART;
   endproperty
   a_err: assert property (p_err) else $error("error code not recorded");

   property p_ready;
      @(posedge SYS_CLK) disable iff (!RST_N)
      state_r == scrc_pkg::SCRC_SHIFT |-> !WORD_READY;
   endproperty
   a_ready: assert property (p_ready) else $error("ready while shifting");

   property p_gap;
      @(posedge SYS_CLK) disable iff (!RST_N)
      RESULT.done |-> !WORD_READY;
   endproperty
   a_gap: assert property (p_gap) else $error("ready during result cycle");

   property p_stray;
      @(posedge SYS_CLK) disable iff (!RST_N)
      take && WORD.kind == scrc_pkg::SCRC_W_EXPECT && !cmd_seen_r
      |=> !RESULT.done && state_r == scrc_pkg::SCRC_IDLE;
   endproperty
   a_stray: assert property (p_stray) else $error("expected word without check command used");

   property p_fail_count;
      @(posedge SYS_CLK) disable iff (!RST_N)
      mismatch && FAIL_COUNT != 4'hf |=> FAIL_COUNT == $past(FAIL_COUNT) + 4'h1;
   endproperty
   a_fail_count: assert property (p_fail_count) else $error("failure not counted");

   // The error code stays until reset, so a later good section cannot hide it
   property p_err_sticky;
      @(posedge SYS_CLK) disable iff (!RST_N)
      BOOT_ERR == 4'h4 |=> BOOT_ERR == 4'h4;
   endproperty
   a_err_sticky: assert property (p_err_sticky) else $error("error code lost");

   // No disable here: this one watches the reset cycles themselves
   property p_reset_clear;
      @(posedge SYS_CLK)
      !RST_N |=> crc_r == 32'h00000000 && FAIL_COUNT == 4'h0 && BOOT_ERR == 4'h0 && !RESULT.done;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear state");

   c_match: cover property (@(posedge SYS_CLK) disable iff (!RST_N) RESULT.done && RESULT.match);
   c_miss: cover property (@(posedge SYS_CLK) disable iff (!RST_N) RESULT.done && !RESULT.match);
   c_err: cover property (@(posedge SYS_CLK) disable iff (!RST_N) BOOT_ERR == 4'h4);
   c_res3: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
      take && WORD.kind == scrc_pkg::SCRC_W_DATA && WORD.bytes == 2'h3);
   c_chain: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
      take && WORD.kind == scrc_pkg::SCRC_W_ADDR && WORD.chain);
endmodule : scrc_checker

// [logic/scrc_pkg.sv]
/*
 Package for the section checksum checker: polynomial, masks, command word,
 error code and the packed carriers between source, engine and status logic.
 Assumes nothing of its surroundings beyond a SystemVerilog-2012 compiler.
*/
package scrc_pkg;
   localparam logic [31:0] POLY = 32'h04c11db7;
   localparam logic [31:0] TOP_MASK = 32'h80000000;
   localparam logic [31:0] CRC_RESET = 32'h00000000;
   localparam logic [31:0] RES_MASK1 = 32'h000000ff;
   localparam logic [31:0] RES_MASK2 = 32'h0000ffff;
   localparam logic [31:0] RES_MASK3 = 32'h000fffff;
   localparam logic [5:0] WORD_BITS = 6'h20;
   localparam logic [5:0] RES_BITS1 = 6'h08;
   localparam logic [5:0] RES_BITS2 = 6'h10;
   localparam logic [5:0] RES_BITS3 = 6'h18;
   localparam logic [31:0] CMD_CHECK = 32'h58535902;
   localparam logic [3:0] ERR_NONE = 4'h0;
   localparam logic [3:0] ERR_BAD_CHECKSUM = 4'h4;
   localparam logic [3:0] FAIL_MAX_DEF = 4'h3;

   // Word kinds as flagged by the image source
   typedef enum logic [2:0] {
      SCRC_W_ADDR = 3'h0,
      SCRC_W_SIZE = 3'h1,
      SCRC_W_DATA = 3'h2,
      SCRC_W_CMD = 3'h3,
      SCRC_W_EXPECT = 3'h4,
      SCRC_W_OFFSET = 3'h5
   } scrc_kind_type;

   typedef struct packed {
      scrc_kind_type kind;
      logic [31:0] data;
      logic [1:0] bytes; // Valid bytes of a DATA word, 0 means all four
      logic chain;       // ADDR only: keep running value from previous section
   } scrc_word_type;

   typedef struct packed {
      logic done;
      logic match;
      logic [31:0] value;
   } scrc_result_type;

   // Gray along IDLE->SHIFT->IDLE and IDLE->EXP->IDLE: one bit flips per step
   typedef enum logic [1:0] {
      SCRC_IDLE = 2'b00,
      SCRC_SHIFT = 2'b01,
      SCRC_EXP = 2'b10
   } scrc_state_type;
endpackage : scrc_pkg

// [testbench/scrc_source.sv]
/*
 Model of the boot image source: queues tagged image words and offers them
 to the checker one at a time. Assumes the bench pushes whole sections.
*/
`timescale 1ns/1ps
module scrc_source (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic stall,
   input wire logic word_ready,
   output logic word_valid,
   output scrc_pkg::scrc_word_type word
);
   scrc_pkg::scrc_word_type q[$];

   // Bench queues addr, size, data, then check word, expected value, offset
   task automatic push(input scrc_pkg::scrc_word_type w);
      q.push_back(w);
   endtask : push

   // A word stands until taken; idle data toggles so nothing stale looks valid
   always @(posedge clk) begin
      if (!rst_n) begin
         word_valid <= 1'b0;
         word <= '0;
      end else if (!word_valid || word_ready) begin
         if (q.size() > 0 && !stall) begin
            word <= q.pop_front();
            word_valid <= 1'b1;
         end else begin
            word_valid <= 1'b0;
            word.data <= ~word.data;
         end
      end
   end
endmodule : scrc_source

// [testbench/test_section_crc32_checker.sv]
/*
 Self-checking bench for the section checksum checker: a table of sections,
 then mismatches, a stray expected word and a reset in mid-run.
 Assumes the source model in scrc_source.sv.
*/
`timescale 1ns/1ps
module test_section_crc32_checker;
   typedef struct {logic [31:0] addr; int nbytes; logic chain; logic slow;} scrc_row_type;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic stall = 1'b0;
   logic slow = 1'b0;
   logic [3:0] fail_max = 4'h1;
   logic word_valid, word_ready, corruption_message_msg, boot_restart;
   logic [3:0] boot_err, fail_count;
   scrc_pkg::scrc_word_type word;
   scrc_pkg::scrc_result_type result;
   int mismatches = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [31:0] crc = '0;
   bit seen;
   scrc_row_type rows[6] = '{'{32'h10800000, 64, 1'b0, 1'b0}, '{32'h10800040, 12, 1'b0, 1'b1},
      '{32'h00001000, 5, 1'b0, 1'b0}, '{32'h00002000, 6, 1'b1, 1'b1},
      '{32'h00003000, 7, 1'b1, 1'b0}, '{32'h00004000, 0, 1'b0, 1'b0}};

   always #2.5 sys_clk = ~sys_clk;

   scrc_checker scrc_checker_inst (.SYS_CLK(sys_clk), .RST_N(rst_n), .WORD_VALID(word_valid),
      .WORD_READY(word_ready), .WORD(word), .FAIL_MAX(fail_max), .RESULT(result),
      .CORRUPTION_MESSAGE_MSG(corruption_message_msg), .BOOT_RESTART(boot_restart), .BOOT_ERR(boot_err), .FAIL_COUNT(fail_count));
   scrc_source scrc_source_inst (.clk(sys_clk), .rst_n(rst_n), .stall(stall), .word_ready(word_ready),
      .word_valid(word_valid), .word(word));

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // Reference fold: top bit out, input bit into bit 0, polynomial on carry
   function automatic logic [31:0] fold(input logic [31:0] c, input logic [31:0] v, input int n);
      logic top;
      for (int b = n - 1; b >= 0; b--) begin
         top = c[31];
         c = {c[30:0], v[b]};
         if (top) c = c ^ scrc_pkg::POLY;
      end
      return c;
   endfunction : fold

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : summarize

   // Queues one section and its check; bad flips bit 0 of the expected value
   task automatic section(input scrc_row_type r, input logic bad);
      logic [31:0] d;
      logic [31:0] m;
      if (!r.chain) crc = '0;
      crc = fold(crc, r.addr, 32);
      crc = fold(crc, 32'(r.nbytes), 32);
      scrc_source_inst.push('{scrc_pkg::SCRC_W_ADDR, r.addr, 2'h0, r.chain});
      scrc_source_inst.push('{scrc_pkg::SCRC_W_SIZE, 32'(r.nbytes), 2'h0, 1'b0});
      for (int i = 0; i < (r.nbytes + 3) / 4; i++) begin
         d = 32'hdeadbeef + 32'(i) * 32'h01020304;
         m = (r.nbytes % 4 == 1) ? 32'h000000ff : (r.nbytes % 4 == 2) ? 32'h0000ffff : 32'h000fffff;
         if (i < r.nbytes / 4) crc = fold(crc, d, 32);
         else crc = fold(crc, d & m, 8 * (r.nbytes % 4));
         scrc_source_inst.push('{scrc_pkg::SCRC_W_DATA, d, (i < r.nbytes / 4) ? 2'h0 : 2'(r.nbytes % 4), 1'b0});
      end
      scrc_source_inst.push('{scrc_pkg::SCRC_W_CMD, scrc_pkg::CMD_CHECK, 2'h0, 1'b0});
      scrc_source_inst.push('{scrc_pkg::SCRC_W_EXPECT, crc ^ 32'(bad), 2'h0, 1'b0});
      scrc_source_inst.push('{scrc_pkg::SCRC_W_OFFSET, 32'hffffffa8, 2'h0, 1'b0});
      seen = 1'b0;
      for (int i = 0; i < 3000 && !seen; i++) begin
         @(negedge sys_clk);
         seen = (result.done === 1'b1);
      end
      chk("done", 32'h1, 32'(seen));
      chk("match", 32'(!bad), 32'(result.match));
      chk("value", crc, result.value);
      chk("corruption_message", 32'(bad), 32'(corruption_message_msg));
      chk("restart", 32'(bad), 32'(boot_restart));
      @(negedge sys_clk);
      chk("done pulse", 32'h0, 32'(result.done));
   endtask : section

   // Stall the source every other pair of cycles on slow rows
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      stall <= slow && cyc[1];
      if (cyc == 20000) begin
         mismatches++;
         summarize();
      end
   end

   initial begin
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(negedge sys_clk);
      chk("ready", 32'h1, 32'(word_ready));
      chk("err", 32'h0, 32'(boot_err));
      foreach (rows[i]) begin
         slow = rows[i].slow;
         section(rows[i], 1'b0);
         $display("test row %0d done", i);
      end
      slow = 1'b0;
      section(rows[2], 1'b1);
      chk("count", 32'h1, 32'(fail_count));
      chk("err", 32'h0, 32'(boot_err));
      section(rows[3], 1'b1);
      chk("count", 32'h2, 32'(fail_count));
      chk("err", 32'(scrc_pkg::ERR_BAD_CHECKSUM), 32'(boot_err));
      $display("test mismatch done");
      scrc_source_inst.push('{scrc_pkg::SCRC_W_EXPECT, crc, 2'h0, 1'b0});
      seen = 1'b0;
      repeat (6) begin
         @(negedge sys_clk);
         seen = seen || (result.done !== 1'b0);
      end
      chk("stray expect", 32'h0, 32'(seen));
      $display("test stray done");
      scrc_source_inst.push('{scrc_pkg::SCRC_W_ADDR, 32'h00005000, 2'h0, 1'b0});
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(negedge sys_clk);
      chk("count", 32'h0, 32'(fail_count));
      chk("err", 32'h0, 32'(boot_err));
      chk("ready", 32'h1, 32'(word_ready));
      crc = '0;
      section(rows[4], 1'b0);
      $display("test reset done");
      summarize();
   end
endmodule : test_section_crc32_checker
